// ===== secondary_status_mem_base_defines.svh
// constants for the secondary status and memory base register block
`ifndef SECONDARY_STATUS_MEM_BASE_DEFINES_SVH
`define SECONDARY_STATUS_MEM_BASE_DEFINES_SVH
`define STATUS_DWORD_ADDR    8'h1c
`define MEM_BASE_DWORD_ADDR  8'h20
`define STATUS_REG_OFFSET    8'h1e
`define MEM_BASE_REG_OFFSET  8'h20
`define ST_HIGH_SPEED_BIT    5
`define ST_FAST_B2B_BIT      7
`define ST_DATA_PAR_BIT      8
`define ST_DEVSEL_LO_BIT     9
`define ST_SIG_TABORT_BIT    11
`define ST_RCV_TABORT_BIT    12
`define ST_RCV_MABORT_BIT    13
`define ST_RCV_SERR_BIT      14
`define ST_DET_PERR_BIT      15
`define DEVSEL_TIMING_VALUE  2'h1
`define MEM_BASE_RESET       12'h000
`endif

// ===== secondary_status_mem_base_pkg.sv
// types for the secondary status and memory base register block
package secondary_status_mem_base_pkg;
	typedef logic [11:0] window_field_t;
	typedef logic [15:0] half_reg_t;
endpackage

// ===== secondary_status_mem_base_regs.sv
// secondary status and memory base configuration registers
`timescale 1ns/10ps
`include "secondary_status_mem_base_defines.svh"
module secondary_status_mem_base_regs
	import secondary_status_mem_base_pkg::*;
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	// configuration access
	input  wire logic        cfg_read_i,
	input  wire logic        cfg_write_i,
	input  wire logic [7:0]  cfg_dword_addr_i,
	input  wire logic [3:0]  cfg_byte_en_n_i,
	input  wire logic [31:0] cfg_wdata_i,
	output logic      [31:0] cfg_rdata_o,
	output logic             cfg_hit_o,
	// secondary bus events
	input  wire logic        high_speed_strap_pin_i,
	input  wire logic        parity_resp_enable_i,
	input  wire logic        sec_master_active_i,
	input  wire logic        sec_perr_seen_i,
	input  wire logic        sec_parity_error_i,
	input  wire logic        sec_target_abort_sent_i,
	input  wire logic        sec_target_abort_rcvd_i,
	input  wire logic        sec_master_abort_rcvd_i,
	input  wire logic        sec_serr_seen_i,
	// memory window decode
	input  wire logic [11:0] mem_limit_i,
	input  wire logic [31:0] decode_addr_i,
	output logic             mem_window_hit_o,
	output logic [11:0]      mem_window_base_o
);
	logic          data_parity_detected;
	logic          signaled_target_abort;
	logic          received_target_abort;
	logic          received_master_abort;
	logic          received_system_error;
	logic          detected_parity_error;
	logic          strap_q;
	window_field_t memory_window_base;
	half_reg_t     secondary_bus_status;
	half_reg_t     base_half;
	logic [31:0]   next_rdata;

	// decode
	wire sel_status = cfg_dword_addr_i == `STATUS_DWORD_ADDR;
	wire sel_base   = cfg_dword_addr_i == `MEM_BASE_DWORD_ADDR;
	wire st_wr_lo   = cfg_write_i && sel_status && !cfg_byte_en_n_i[2];
	wire st_wr_hi   = cfg_write_i && sel_status && !cfg_byte_en_n_i[3];
	wire base_wr_lo = cfg_write_i && sel_base && !cfg_byte_en_n_i[0];
	wire base_wr_hi = cfg_write_i && sel_base && !cfg_byte_en_n_i[1];
	wire clr_dpar   = st_wr_hi && cfg_wdata_i[24];
	wire clr_sta    = st_wr_hi && cfg_wdata_i[27];
	wire clr_rta    = st_wr_hi && cfg_wdata_i[28];
	wire clr_rma    = st_wr_hi && cfg_wdata_i[29];
	wire clr_rse    = st_wr_hi && cfg_wdata_i[30];
	wire clr_dpe    = st_wr_hi && cfg_wdata_i[31];
	wire set_dpar   = sec_master_active_i && parity_resp_enable_i
		&& (sec_perr_seen_i || sec_parity_error_i);

	// status image
	always_comb begin
		secondary_bus_status = 16'h0000;
		secondary_bus_status[`ST_HIGH_SPEED_BIT] = strap_q;
		secondary_bus_status[`ST_FAST_B2B_BIT] = 1'b1;
		secondary_bus_status[`ST_DATA_PAR_BIT] = data_parity_detected;
		secondary_bus_status[`ST_DEVSEL_LO_BIT +: 2] = `DEVSEL_TIMING_VALUE;
		secondary_bus_status[`ST_SIG_TABORT_BIT] = signaled_target_abort;
		secondary_bus_status[`ST_RCV_TABORT_BIT] = received_target_abort;
		secondary_bus_status[`ST_RCV_MABORT_BIT] = received_master_abort;
		secondary_bus_status[`ST_RCV_SERR_BIT] = received_system_error;
		secondary_bus_status[`ST_DET_PERR_BIT] = detected_parity_error;
	end

	assign base_half = {memory_window_base, 4'h0};

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_status) begin
			next_rdata = {secondary_bus_status, 16'h0000};
		end else if (sel_base) begin
			next_rdata = {16'h0000, base_half};
		end
	end

	// strap sampled every clock
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			strap_q <= 1'b0;
		end else begin
			strap_q <= high_speed_strap_pin_i;
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			data_parity_detected  <= 1'b0;
			signaled_target_abort <= 1'b0;
			received_target_abort <= 1'b0;
			received_master_abort <= 1'b0;
			received_system_error <= 1'b0;
			detected_parity_error <= 1'b0;
		end else begin
			data_parity_detected  <= set_dpar || (data_parity_detected && !clr_dpar);
			signaled_target_abort <= sec_target_abort_sent_i
				|| (signaled_target_abort && !clr_sta);
			received_target_abort <= sec_target_abort_rcvd_i
				|| (received_target_abort && !clr_rta);
			received_master_abort <= sec_master_abort_rcvd_i
				|| (received_master_abort && !clr_rma);
			received_system_error <= sec_serr_seen_i
				|| (received_system_error && !clr_rse);
			detected_parity_error <= sec_parity_error_i
				|| (detected_parity_error && !clr_dpe);
		end
	end

	// memory base, byte lanes 0 and 1
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			memory_window_base <= `MEM_BASE_RESET;
		end else begin
			if (base_wr_lo) begin
				memory_window_base[3:0] <= cfg_wdata_i[7:4];
			end
			if (base_wr_hi) begin
				memory_window_base[11:4] <= cfg_wdata_i[15:8];
			end
		end
	end

	// read data register
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_rdata_o <= 32'h0000_0000;
			cfg_hit_o   <= 1'b0;
		end else begin
			cfg_rdata_o <= cfg_read_i ? next_rdata : 32'h0000_0000;
			cfg_hit_o   <= (cfg_read_i || cfg_write_i) && (sel_status || sel_base);
		end
	end

	// window decode on 1MB granules
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			mem_window_hit_o <= 1'b0;
		end else begin
			mem_window_hit_o <= (decode_addr_i[31:20] >= memory_window_base)
				&& (decode_addr_i[31:20] <= mem_limit_i);
		end
	end

	assign mem_window_base_o = memory_window_base;

	// checks
	property p_w1c_clear;
		@(posedge clock_i) disable iff (reset_i)
		(clr_rma && !sec_master_abort_rcvd_i) |=> !received_master_abort;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("master abort flag not cleared");

	property p_zero_write_keeps;
		@(posedge clock_i) disable iff (reset_i)
		(received_system_error && st_wr_hi && !cfg_wdata_i[30]) |=> received_system_error;
	endproperty
	a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("flag lost on zero write");

	property p_reserved_zero;
		@(posedge clock_i) disable iff (reset_i)
		(cfg_read_i && sel_status) |=> (cfg_rdata_o[20:16] == 5'h00 && !cfg_rdata_o[22]);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

	property p_strap;
		@(posedge clock_i) disable iff (reset_i)
		(cfg_read_i && sel_status) |=> cfg_rdata_o[21] == $past(strap_q);
	endproperty
	a_strap: assert property (p_strap) else $error("high speed bit wrong");

	property p_fixed_bits;
		@(posedge clock_i) disable iff (reset_i)
		(cfg_read_i && sel_status) |=> (cfg_rdata_o[23] && cfg_rdata_o[26:25] == 2'h1);
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

	property p_parity_set;
		@(posedge clock_i) disable iff (reset_i)
		(sec_master_active_i && parity_resp_enable_i && sec_perr_seen_i) |=> data_parity_detected;
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("data parity flag not set");

	property p_parity_gated;
		@(posedge clock_i) disable iff (reset_i)
		(!data_parity_detected && !parity_resp_enable_i) |=> !data_parity_detected;
	endproperty
	a_parity_gated: assert property (p_parity_gated) else $error("data parity set while disabled");

	property p_events_set;
		@(posedge clock_i) disable iff (reset_i)
		(sec_target_abort_sent_i && sec_target_abort_rcvd_i && sec_serr_seen_i)
			|=> (signaled_target_abort && received_target_abort && received_system_error);
	endproperty
	a_events_set: assert property (p_events_set) else $error("event flag not set");

	property p_detect_perr;
		@(posedge clock_i) disable iff (reset_i)
		sec_parity_error_i |=> detected_parity_error;
	endproperty
	a_detect_perr: assert property (p_detect_perr) else $error("detected parity flag not set");

	property p_base_read;
		@(posedge clock_i) disable iff (reset_i)
		(cfg_read_i && sel_base) |=> (cfg_rdata_o[3:0] == 4'h0
			&& cfg_rdata_o[15:4] == $past(memory_window_base) && cfg_rdata_o[31:16] == 16'h0000);
	endproperty
	a_base_read: assert property (p_base_read) else $error("memory base read wrong");

	property p_base_write;
		@(posedge clock_i) disable iff (reset_i)
		(base_wr_lo && base_wr_hi) |=> memory_window_base == $past(cfg_wdata_i[15:4]);
	endproperty
	a_base_write: assert property (p_base_write) else $error("memory base not written");

	property p_window;
		@(posedge clock_i) disable iff (reset_i)
		(decode_addr_i[31:20] < memory_window_base) |=> !mem_window_hit_o;
	endproperty
	a_window: assert property (p_window) else $error("hit below window base");

	property p_lane2_ro;
		@(posedge clock_i) disable iff (reset_i)
		(received_master_abort && st_wr_lo && !st_wr_hi) |=> received_master_abort;
	endproperty
	a_lane2_ro: assert property (p_lane2_ro) else $error("flag lost on lane two");

	property p_sta_hold;
		@(posedge clock_i) disable iff (reset_i)
		(signaled_target_abort && !clr_sta) |=> signaled_target_abort;
	endproperty
	a_sta_hold: assert property (p_sta_hold) else $error("target abort flag lost");

	property p_rta_set;
		@(posedge clock_i) disable iff (reset_i)
		sec_target_abort_rcvd_i |=> received_target_abort;
	endproperty
	a_rta_set: assert property (p_rta_set) else $error("received abort flag unset");

	property p_rma_set;
		@(posedge clock_i) disable iff (reset_i)
		sec_master_abort_rcvd_i |=> received_master_abort;
	endproperty
	a_rma_set: assert property (p_rma_set) else $error("master abort flag unset");

	property p_serr_set;
		@(posedge clock_i) disable iff (reset_i)
		sec_serr_seen_i |=> received_system_error;
	endproperty
	a_serr_set: assert property (p_serr_set) else $error("system error flag unset");

	property p_dpar_master;
		@(posedge clock_i) disable iff (reset_i)
		(!data_parity_detected && !sec_master_active_i) |=> !data_parity_detected;
	endproperty
	a_dpar_master: assert property (p_dpar_master) else $error("data parity set as target");

	property p_dpe_clear;
		@(posedge clock_i) disable iff (reset_i)
		(clr_dpe && !sec_parity_error_i) |=> !detected_parity_error;
	endproperty
	a_dpe_clear: assert property (p_dpe_clear) else $error("parity flag not cleared");

	property p_base_lane_lo;
		@(posedge clock_i) disable iff (reset_i)
		(base_wr_lo && !base_wr_hi) |=> ($stable(memory_window_base[11:4])
			&& memory_window_base[3:0] == $past(cfg_wdata_i[7:4]));
	endproperty
	a_base_lane_lo: assert property (p_base_lane_lo) else $error("base lane zero wrong");

	property p_base_hold;
		@(posedge clock_i) disable iff (reset_i)
		(!base_wr_lo && !base_wr_hi) |=> $stable(memory_window_base);
	endproperty
	a_base_hold: assert property (p_base_hold) else $error("base changed unwritten");

	property p_window_above;
		@(posedge clock_i) disable iff (reset_i)
		(decode_addr_i[31:20] > mem_limit_i) |=> !mem_window_hit_o;
	endproperty
	a_window_above: assert property (p_window_above) else $error("hit above limit");

	property p_window_in;
		@(posedge clock_i) disable iff (reset_i)
		((decode_addr_i[31:20] >= memory_window_base) && (decode_addr_i[31:20] <= mem_limit_i))
			|=> mem_window_hit_o;
	endproperty
	a_window_in: assert property (p_window_in) else $error("miss inside window");

	property p_hit_mapped;
		@(posedge clock_i) disable iff (reset_i)
		((cfg_read_i || cfg_write_i) && (sel_status || sel_base)) |=> cfg_hit_o;
	endproperty
	a_hit_mapped: assert property (p_hit_mapped) else $error("mapped access missed");

	property p_unmapped;
		@(posedge clock_i) disable iff (reset_i)
		((cfg_read_i || cfg_write_i) && !sel_status && !sel_base)
			|=> (!cfg_hit_o && cfg_rdata_o == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");

	property p_rdata_idle;
		@(posedge clock_i) disable iff (reset_i)
		!cfg_read_i |=> cfg_rdata_o == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_status_low;
		@(posedge clock_i) disable iff (reset_i)
		(cfg_read_i && sel_status) |=> cfg_rdata_o[15:0] == 16'h0000;
	endproperty
	a_status_low: assert property (p_status_low) else $error("status low half set");
endmodule

// ===== test_secondary_status_mem_base_regs.sv
// self-checking bench for the secondary status and memory base registers
`timescale 1ns/10ps
module test_secondary_status_mem_base_regs;
	import secondary_status_mem_base_pkg::*;
	logic        clock_i = 0, reset_i = 1, cfg_read_i = 0, cfg_write_i = 0;
	logic [7:0]  cfg_dword_addr_i = 8'h00;
	logic [3:0]  cfg_byte_en_n_i = 4'hf;
	logic [31:0] cfg_wdata_i = 32'h0000_0000, decode_addr_i = 32'h0000_0000;
	logic        strap = 1, resp = 0, mst = 0, mem_window_hit_o, cfg_hit_o;
	logic [5:0]  ev = 6'h00;
	logic [11:0] mem_limit_i = 12'h000, mem_window_base_o, base = 12'h000;
	logic [31:0] cfg_rdata_o, q;
	logic [7:0]  flags = 8'h00;
	logic        h;
	int          fail_count = 0, compares = 0, cycles = 0;
	always #2.5 clock_i = ~clock_i;
	secondary_status_mem_base_regs uut (.clock_i(clock_i), .reset_i(reset_i),
		.cfg_read_i(cfg_read_i), .cfg_write_i(cfg_write_i), .cfg_dword_addr_i(cfg_dword_addr_i),
		.cfg_byte_en_n_i(cfg_byte_en_n_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.cfg_hit_o(cfg_hit_o), .high_speed_strap_pin_i(strap), .parity_resp_enable_i(resp),
		.sec_master_active_i(mst), .sec_perr_seen_i(ev[0]), .sec_parity_error_i(ev[1]),
		.sec_target_abort_sent_i(ev[2]), .sec_target_abort_rcvd_i(ev[3]),
		.sec_master_abort_rcvd_i(ev[4]), .sec_serr_seen_i(ev[5]), .mem_limit_i(mem_limit_i),
		.decode_addr_i(decode_addr_i), .mem_window_hit_o(mem_window_hit_o),
		.mem_window_base_o(mem_window_base_o));
	function automatic logic [15:0] exp_status(input logic [7:0] f, input logic s);
		return {f[7:3], 2'b01, f[0], 1'b1, 1'b0, s, 5'h00};
	endfunction
	function automatic logic exp_hit(input logic [31:0] ad, input logic [11:0] b,
		input logic [11:0] l);
		return ad >= {b, 20'h00000} && ad <= {l, 20'hfffff};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic rd, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clock_i);
		cfg_read_i = rd;
		cfg_write_i = !rd;
		cfg_dword_addr_i = a;
		cfg_byte_en_n_i = be;
		cfg_wdata_i = d;
		@(negedge clock_i);
		cfg_read_i = 0;
		cfg_write_i = 0;
		q = cfg_rdata_o;
		h = cfg_hit_o;
		if (!rd && a == 8'h1c && !be[3]) flags = flags & ~(d[31:24] & 8'hf9);
		if (!rd && a == 8'h20 && !be[0]) base[3:0] = d[7:4];
		if (!rd && a == 8'h20 && !be[1]) base[11:4] = d[15:8];
	endtask
	task automatic read_both();
		access(1'b1, 8'h1c, 4'h0, 32'h0000_0000);
		check({16'h0000, q[31:16]}, {16'h0000, exp_status(flags, strap)});
		check({31'h0, h}, 32'h0000_0001);
		access(1'b1, 8'h20, 4'h0, 32'h0000_0000);
		check(q, {16'h0000, base, 4'h0});
	endtask
	task automatic pulse(input logic [5:0] e, input logic m, input logic r);
		@(negedge clock_i);
		ev = e;
		mst = m;
		resp = r;
		@(negedge clock_i);
		ev = 6'h00;
		flags = flags | {e[1], e[5], e[4], e[3], e[2], 2'b00, m & r & (e[0] | e[1])};
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		logic [7:0] a;
		logic [11:0] hi;
		void'($urandom(18));
		repeat (20) @(posedge clock_i);
		@(negedge clock_i) reset_i = 0;
		repeat (2) @(negedge clock_i);
		read_both();
		pulse(6'h3f, 1'b1, 1'b1);
		read_both();
		access(1'b0, 8'h1c, 4'h8, 32'hffff_ffff); // upper lane disabled, nothing cleared
		access(1'b0, 8'h20, 4'h0, 32'hffff_ffff);
		read_both();
		access(1'b0, 8'h1c, 4'h0, 32'hffff_ffff);
		strap = 1'b0;
		read_both();
		repeat (60) begin
			pulse(6'($urandom), 1'($urandom), 1'($urandom));
			strap = 1'($urandom);
			access(1'b0, 8'h1c, 4'($urandom), $urandom);
			check({31'h0, h}, 32'h0000_0001);
			access(1'b0, 8'h20, 4'($urandom), $urandom);
			check({31'h0, h}, 32'h0000_0001);
			a = 8'($urandom);
			if (a == 8'h1c || a == 8'h20) a = 8'h24;
			access(1'($urandom), a, 4'h0, $urandom);
			check(q, 32'h0000_0000);
			check({31'h0, h}, 32'h0000_0000);
			read_both();
			check({20'h00000, mem_window_base_o}, {20'h00000, base});
			@(negedge clock_i);
			mem_limit_i = base + 12'($urandom % 4);
			case ($urandom % 4)
				0: hi = base;
				1: hi = mem_limit_i;
				2: hi = base - 12'h001;
				default: hi = mem_limit_i + 12'h001;
			endcase
			decode_addr_i = {hi, 20'($urandom)};
			@(negedge clock_i);
			h = exp_hit(decode_addr_i, base, mem_limit_i);
			check({31'h0, mem_window_hit_o}, {31'h0, h});
		end
		// mid-run reset clears flags and base
		pulse(6'h3f, 1'b1, 1'b1);
		access(1'b0, 8'h20, 4'h0, 32'h0000_fff0);
		@(negedge clock_i) reset_i = 1;
		repeat (3) @(negedge clock_i);
		reset_i = 0;
		flags = 8'h00;
		base = 12'h000;
		repeat (2) @(negedge clock_i);
		read_both();
		check({20'h00000, mem_window_base_o}, {20'h00000, base});
		wrap_up();
	end
endmodule
